// File: src/lsbd_decoder.sv
// decode and cycle-cost sequencer for xor/not, string and jump/call forms
// assumes opcode, prefix and modrm bytes are presented together with start
`timescale 1ns/100ps
module lsbd_decoder (
    // clock, reset, enable
    input wire logic clk,
    input wire logic arst_n,
    input wire logic ce,
    // request
    input wire logic start,
    input wire lsbd_pkg::lsbd_instr_t instr,
    input wire logic [15:0] count_register,
    input wire logic bus8,
    // answer
    output logic busy,
    output logic done,
    output lsbd_pkg::lsbd_dec_t result
);
    import lsbd_pkg::*;

    lsbd_regs_t r;
    lsbd_regs_t next_r;
    lsbd_dec_t dec;
    lsbd_cyc_t base;
    lsbd_cyc_t per;
    lsbd_cyc_t xfers;
    lsbd_cyc_t mult;
    logic starred;
    logic mem;
    logic is_string;
    logic [2:0] sub;

    // ----------------------------------------------------------------
    // decode and cost
    // ----------------------------------------------------------------
    // one combinational decode; cost is base + per*n + word penalty
    always_comb begin
        dec = '0;
        base = '0;
        per = '0;
        xfers = XF_NONE;
        starred = 1'b0;
        is_string = 1'b1;
        mem = instr.modrm[7:6] != MOD_REG;
        sub = instr.modrm[5:3];
        dec.op = op_none;
        dec.word = instr.opcode[0];
        dec.mem_operand = mem;
        // single costs first; repeat overrides below
        case (instr.opcode[7:1])
            OPC_STR_MOVE: begin
                dec.op = op_string_move;
                base = CYC_MOVE;
                xfers = XF_TWO;
            end
            OPC_STR_CMP: begin
                dec.op = op_string_compare;
                base = CYC_CMP;
                xfers = XF_TWO;
            end
            OPC_STR_SCAN: begin
                dec.op = op_string_scan;
                base = CYC_SCAN;
                xfers = XF_ONE;
            end
            OPC_STR_LOAD: begin
                dec.op = op_string_load;
                base = CYC_LOAD;
                xfers = XF_ONE;
            end
            OPC_STR_STORE: begin
                dec.op = op_string_store;
                base = CYC_STORE;
                xfers = XF_ONE;
            end
            OPC_STR_IN: begin
                dec.op = op_string_port_input;
                base = CYC_PORT;
            end
            OPC_STR_OUT: begin
                dec.op = op_string_port_output;
                base = CYC_PORT;
            end
            default: begin
                is_string = 1'b0;
            end
        endcase
        // port strings carry no word penalty, the others are starred
        starred = is_string && xfers != XF_NONE;
        if (is_string) begin
            dec.mem_operand = 1'b1;
            // f2 repeats every string form, f3 only compare and scan
            if (instr.rep_valid && (instr.rep_byte == OPC_REP_PLAIN
                    || (instr.rep_byte[7:1] == OPC_REP
                    && (dec.op == op_string_compare || dec.op == op_string_scan)))) begin
                dec.rep_active = 1'b1;
                dec.stop_on_equal = instr.rep_byte[0];
                case (dec.op)
                    op_string_compare: begin
                        base = CYC_RCMP_BASE;
                        per = CYC_RCMP_ELEM;
                    end
                    op_string_scan: begin
                        base = CYC_RSCAN_BASE;
                        per = CYC_RSCAN_ELEM;
                    end
                    op_string_load: begin
                        base = CYC_RLOAD_BASE;
                        per = CYC_RLOAD_ELEM;
                    end
                    op_string_store: begin
                        base = CYC_RSTORE_BASE;
                        per = CYC_RSTORE_ELEM;
                    end
                    default: begin
                        base = CYC_RMOVE_BASE;
                        per = CYC_RMOVE_ELEM;
                    end
                endcase
            end
        end else if (instr.opcode[7:2] == OPC_XOR_RM) begin
            dec.op = op_xor;
            dec.reg_dest = instr.opcode[1];
            base = mem ? CYC_XOR_RM : CYC_XOR_RR;
            // memory destination is read then written back
            xfers = !mem ? XF_NONE : (instr.opcode[1] ? XF_ONE : XF_TWO);
            starred = 1'b1;
        end else if (instr.opcode[7:2] == OPC_IMM_GRP && sub == SUB_XOR) begin
            dec.op = op_xor;
            base = mem ? CYC_IMM_M : CYC_IMM_R;
            xfers = mem ? XF_TWO : XF_NONE;
            starred = 1'b1;
        end else if (instr.opcode[7:1] == OPC_XOR_ACC) begin
            dec.op = op_xor;
            dec.mem_operand = 1'b0;
            base = instr.opcode[0] ? CYC_ACC_W : CYC_ACC_B;
        end else if (instr.opcode[7:1] == OPC_UNARY_GRP && sub == SUB_NOT) begin
            dec.op = op_not;
            base = mem ? CYC_NOT_M : CYC_NOT_R;
            xfers = mem ? XF_TWO : XF_NONE;
            starred = 1'b1;
        end else begin
            // branch forms: word-sized, costs listed outright, with 8-bit bus variants for calls and memory-indirect jumps only
            dec.word = 1'b1;
            dec.mem_operand = 1'b0;
            case (instr.opcode)
                OPC_JMP_SHORT, OPC_JMP_NEAR: begin
                    dec.op = op_unconditional_jump;
                    base = CYC_JMP_DIRECT;
                end
                OPC_JMP_FAR: begin
                    dec.op = op_unconditional_jump;
                    dec.far = 1'b1;
                    base = CYC_JMP_DIRECT;
                end
                OPC_CALL_NEAR: begin
                    dec.op = op_call;
                    base = bus8 ? CYC_CALL_NEAR8 : CYC_CALL_NEAR;
                end
                OPC_CALL_FAR: begin
                    dec.op = op_call;
                    dec.far = 1'b1;
                    base = bus8 ? CYC_CALL_FAR8 : CYC_CALL_FAR;
                end
                OPC_IND_GRP: begin
                    dec.indirect = 1'b1;
                    dec.mem_operand = mem;
                    dec.far = sub == SUB_JMP_FAR || sub == SUB_CALL_FAR;
                    // far indirect forms need a memory pointer; mod 11 stays illegal
                    if (sub == SUB_JMP_NEAR) begin
                        dec.op = op_unconditional_jump;
                        base = !mem ? CYC_JMP_IND_R : (bus8 ? CYC_JMP_IND_M8 : CYC_JMP_IND_M);
                    end else if (sub == SUB_JMP_FAR && mem) begin
                        dec.op = op_unconditional_jump;
                        base = bus8 ? CYC_JMP_FAR_IND8 : CYC_JMP_FAR_IND;
                    end else if (sub == SUB_CALL_NEAR) begin
                        dec.op = op_call;
                        if (mem) begin
                            base = bus8 ? CYC_CALL_IND_M8 : CYC_CALL_IND_M;
                        end else begin
                            base = bus8 ? CYC_CALL_IND_R8 : CYC_CALL_IND_R;
                        end
                    end else if (sub == SUB_CALL_FAR && mem) begin
                        dec.op = op_call;
                        base = bus8 ? CYC_CALL_FAR_IND8 : CYC_CALL_FAR_IND;
                    end
                end
                default: begin
                    dec.op = op_none;
                end
            endcase
        end
        mult = dec.rep_active ? {8'h00, count_register} : CYC_ONE;
        dec.illegal = dec.op == op_none;
        if (dec.illegal) begin
            dec.cycles = '0;
        end else if (bus8 && dec.word && starred) begin
            dec.cycles = base + per * mult + CYC_WORD_XFER * xfers * mult;
        end else begin
            dec.cycles = base + per * mult;
        end
    end

    // ----------------------------------------------------------------
    // cost sequencer
    // ----------------------------------------------------------------
    // busy stands exactly the decoded cycle count, then done pulses once
    always_comb begin
        next_r = r;
        next_r.done = 1'b0;
        case (r.state)
            st_idle: begin
                if (start) begin
                    next_r.res = dec;
                    if (dec.illegal) begin
                        next_r.done = 1'b1; // no cost to run, answer at once
                    end else begin
                        next_r.state = st_run;
                        next_r.busy = 1'b1;
                        next_r.cnt = dec.cycles - CYC_ONE;
                    end
                end
            end
            st_run: begin
                if (r.cnt == '0) begin
                    next_r.state = st_idle;
                    next_r.busy = 1'b0;
                    next_r.done = 1'b1;
                end else begin
                    next_r.cnt = r.cnt - CYC_ONE;
                end
            end
            default: begin
                next_r = REGS_RST;
            end
        endcase
    end

    // state register; enable low freezes everything
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            r <= REGS_RST;
        end else if (ce) begin
            r <= next_r;
        end
    end

    assign busy = r.busy;
    assign done = r.done;
    assign result = r.res;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    logic acc;
    lsbd_cyc_t run_len;
    assign acc = ce && start && r.state == st_idle;

    // counts enabled busy cycles, only read by the checks
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            run_len <= '0;
        end else if (ce) begin
            run_len <= acc ? '0 : (r.busy ? run_len + CYC_ONE : run_len);
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    property p_len;
        done && !result.illegal |-> run_len == result.cycles;
    endproperty
    a_len: assert property (p_len) else $error("busy length differs from cost");
    property p_xor_rr;
        acc && instr.opcode[7:2] == OPC_XOR_RM && !mem |=> result.cycles == CYC_XOR_RR;
    endproperty
    a_xor_rr: assert property (p_xor_rr) else $error("xor register cost wrong");
    property p_not_mem;
        acc && !bus8 && instr.opcode[7:1] == OPC_UNARY_GRP && sub == SUB_NOT && mem
            |=> result.op == op_not && result.cycles == CYC_NOT_M;
    endproperty
    a_not_mem: assert property (p_not_mem) else $error("invert memory cost wrong");
    property p_rcmp;
        acc && !bus8 && dec.rep_active && dec.op == op_string_compare
            |=> result.cycles == CYC_RCMP_BASE + CYC_RCMP_ELEM * {8'h00, $past(count_register)};
    endproperty
    a_rcmp: assert property (p_rcmp) else $error("repeated compare cost wrong");
    property p_rstore;
        acc && !bus8 && dec.rep_active && dec.op == op_string_store
            |=> result.cycles == CYC_RSTORE_BASE + CYC_RSTORE_ELEM * {8'h00, $past(count_register)};
    endproperty
    a_rstore: assert property (p_rstore) else $error("repeated store cost wrong");
    property p_port;
        acc && !instr.rep_valid && instr.opcode[7:1] == OPC_STR_IN |=> result.cycles == CYC_PORT;
    endproperty
    a_port: assert property (p_port) else $error("port input cost wrong");
    property p_word_pen;
        acc && bus8 && !instr.rep_valid && instr.opcode == {OPC_STR_LOAD, 1'b1}
            |=> result.cycles == CYC_LOAD + CYC_WORD_XFER;
    endproperty
    a_word_pen: assert property (p_word_pen) else $error("word penalty wrong");
    property p_jmp_short;
        acc && instr.opcode == OPC_JMP_SHORT |=> result.op == op_unconditional_jump ##0 busy;
    endproperty
    a_jmp_short: assert property (p_jmp_short) else $error("short jump not run");
    property p_call8;
        acc && bus8 && instr.opcode == OPC_CALL_NEAR |=> result.cycles == CYC_CALL_NEAR8;
    endproperty
    a_call8: assert property (p_call8) else $error("near call cost wrong");
    property p_width;
        acc && !dec.illegal && is_string |=> result.word == $past(instr.opcode[0]);
    endproperty
    a_width: assert property (p_width) else $error("width bit lost");
    property p_move_rep;
        acc && instr.rep_valid && instr.rep_byte == OPC_REP_PLAIN && is_string
            |=> result.rep_active;
    endproperty
    a_move_rep: assert property (p_move_rep) else $error("repeat prefix ignored");

    c_rep_done: cover property (r.res.rep_active && done);
    c_illegal: cover property (done && result.illegal);
    c_pen: cover property (acc && bus8 && dec.word && starred);
endmodule

// File: src/lsbd_pkg.sv
// constants, types and the state record of the string/branch decoder
// assumes opcode bytes arrive already fetched; one clock domain
package lsbd_pkg;
    typedef logic [23:0] lsbd_cyc_t;

    // ----------------------------------------------------------------
    // opcode patterns
    // ----------------------------------------------------------------
    localparam logic [5:0] OPC_XOR_RM = 6'h0c;     // 001100dw
    localparam logic [5:0] OPC_IMM_GRP = 6'h20;    // 100000sw
    localparam logic [6:0] OPC_XOR_ACC = 7'h1a;    // 0011010w
    localparam logic [6:0] OPC_UNARY_GRP = 7'h7b;  // 1111011w
    localparam logic [6:0] OPC_STR_MOVE = 7'h52;
    localparam logic [6:0] OPC_STR_CMP = 7'h53;
    localparam logic [6:0] OPC_STR_SCAN = 7'h57;
    localparam logic [6:0] OPC_STR_LOAD = 7'h56;
    localparam logic [6:0] OPC_STR_STORE = 7'h55;
    localparam logic [6:0] OPC_STR_IN = 7'h36;
    localparam logic [6:0] OPC_STR_OUT = 7'h37;
    localparam logic [6:0] OPC_REP = 7'h79;        // 1111001z
    localparam logic [7:0] OPC_REP_PLAIN = 8'hf2;
    localparam logic [7:0] OPC_JMP_SHORT = 8'heb;
    localparam logic [7:0] OPC_JMP_NEAR = 8'he9;
    localparam logic [7:0] OPC_JMP_FAR = 8'hea;
    localparam logic [7:0] OPC_CALL_NEAR = 8'he8;
    localparam logic [7:0] OPC_CALL_FAR = 8'h9a;
    localparam logic [7:0] OPC_IND_GRP = 8'hff;
    localparam logic [2:0] SUB_XOR = 3'h6;
    localparam logic [2:0] SUB_NOT = 3'h2;
    localparam logic [2:0] SUB_CALL_NEAR = 3'h2;
    localparam logic [2:0] SUB_CALL_FAR = 3'h3;
    localparam logic [2:0] SUB_JMP_NEAR = 3'h4;
    localparam logic [2:0] SUB_JMP_FAR = 3'h5;
    localparam logic [1:0] MOD_REG = 2'h3;

    // ----------------------------------------------------------------
    // cycle costs (suffix 8 = 8-bit bus variant)
    // ----------------------------------------------------------------
    localparam lsbd_cyc_t CYC_ONE = 24'h1;
    localparam lsbd_cyc_t CYC_XOR_RR = 24'h3;
    localparam lsbd_cyc_t CYC_XOR_RM = 24'ha;
    localparam lsbd_cyc_t CYC_IMM_R = 24'h4;
    localparam lsbd_cyc_t CYC_IMM_M = 24'h10;
    localparam lsbd_cyc_t CYC_ACC_B = 24'h3;
    localparam lsbd_cyc_t CYC_ACC_W = 24'h4;
    localparam lsbd_cyc_t CYC_NOT_R = 24'h3;
    localparam lsbd_cyc_t CYC_NOT_M = 24'ha;
    localparam lsbd_cyc_t CYC_MOVE = 24'he;
    localparam lsbd_cyc_t CYC_CMP = 24'h16;
    localparam lsbd_cyc_t CYC_SCAN = 24'hf;
    localparam lsbd_cyc_t CYC_LOAD = 24'hc;
    localparam lsbd_cyc_t CYC_STORE = 24'ha;
    localparam lsbd_cyc_t CYC_PORT = 24'he;
    localparam lsbd_cyc_t CYC_RMOVE_BASE = 24'h8;
    localparam lsbd_cyc_t CYC_RMOVE_ELEM = 24'h8;
    localparam lsbd_cyc_t CYC_RCMP_BASE = 24'h5;
    localparam lsbd_cyc_t CYC_RCMP_ELEM = 24'h16;
    localparam lsbd_cyc_t CYC_RSCAN_BASE = 24'h5;
    localparam lsbd_cyc_t CYC_RSCAN_ELEM = 24'hf;
    localparam lsbd_cyc_t CYC_RLOAD_BASE = 24'h6;
    localparam lsbd_cyc_t CYC_RLOAD_ELEM = 24'hb;
    localparam lsbd_cyc_t CYC_RSTORE_BASE = 24'h6;
    localparam lsbd_cyc_t CYC_RSTORE_ELEM = 24'h9;
    localparam lsbd_cyc_t CYC_JMP_DIRECT = 24'he;
    localparam lsbd_cyc_t CYC_JMP_IND_R = 24'hb;
    localparam lsbd_cyc_t CYC_JMP_IND_M = 24'h11;
    localparam lsbd_cyc_t CYC_JMP_IND_M8 = 24'h15;
    localparam lsbd_cyc_t CYC_JMP_FAR_IND = 24'h1a;
    localparam lsbd_cyc_t CYC_JMP_FAR_IND8 = 24'h22;
    localparam lsbd_cyc_t CYC_CALL_NEAR = 24'hf;
    localparam lsbd_cyc_t CYC_CALL_NEAR8 = 24'h13;
    localparam lsbd_cyc_t CYC_CALL_IND_R = 24'hd;
    localparam lsbd_cyc_t CYC_CALL_IND_R8 = 24'h11;
    localparam lsbd_cyc_t CYC_CALL_IND_M = 24'h13;
    localparam lsbd_cyc_t CYC_CALL_IND_M8 = 24'h1b;
    localparam lsbd_cyc_t CYC_CALL_FAR = 24'h17;
    localparam lsbd_cyc_t CYC_CALL_FAR8 = 24'h1f;
    localparam lsbd_cyc_t CYC_CALL_FAR_IND = 24'h26;
    localparam lsbd_cyc_t CYC_CALL_FAR_IND8 = 24'h36;
    localparam lsbd_cyc_t CYC_WORD_XFER = 24'h4;
    localparam lsbd_cyc_t XF_NONE = 24'h0;
    localparam lsbd_cyc_t XF_ONE = 24'h1;
    localparam lsbd_cyc_t XF_TWO = 24'h2;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        op_none, op_xor, op_not, op_string_move, op_string_compare, op_string_scan,
        op_string_load, op_string_store, op_string_port_input, op_string_port_output,
        op_unconditional_jump, op_call
    } lsbd_op_t;

    typedef enum logic [0:0] {st_idle = 1'b0, st_run = 1'b1} lsbd_state_t;

    typedef struct packed {
        logic rep_valid;
        logic [7:0] rep_byte;
        logic [7:0] opcode;
        logic [7:0] modrm;
    } lsbd_instr_t;

    typedef struct packed {
        lsbd_op_t op;
        logic illegal;
        logic word;
        logic reg_dest;
        logic mem_operand;
        logic rep_active;
        logic stop_on_equal;
        logic far;
        logic indirect;
        lsbd_cyc_t cycles;
    } lsbd_dec_t;

    typedef struct packed {
        lsbd_state_t state;
        logic busy;
        logic done;
        lsbd_cyc_t cnt;
        lsbd_dec_t res;
    } lsbd_regs_t;

    localparam lsbd_regs_t REGS_RST = '0;
endpackage

// File: dv/lsbd_prog_mem.sv
// program memory model feeding opcode, prefix and modrm bytes to the decoder
// assumes the bench fills the bytes at the fetch address before each start
`timescale 1ns/100ps
module lsbd_prog_mem (
    // fetch address
    input wire logic [7:0] pc,
    // fetched instruction bytes
    output lsbd_pkg::lsbd_instr_t instr
);
    import lsbd_pkg::*;

    logic [7:0] mem [0:255];
    logic pre;

    // a repeat prefix moves opcode and modrm one byte on
    assign pre = mem[pc][7:1] == OPC_REP;
    always_comb begin
        instr.rep_valid = pre;
        instr.rep_byte = pre ? mem[pc] : 8'h00;
        instr.opcode = pre ? mem[pc + 8'h01] : mem[pc];
        instr.modrm = pre ? mem[pc + 8'h02] : mem[pc + 8'h01];
    end
endmodule

// File: dv/tb_logic_string_branch_decode.sv
// self-checking bench for the xor/not, string and jump/call decoder
// assumes one 40 MHz clock and the program memory model at address zero
`timescale 1ns/100ps
module tb_logic_string_branch_decode;
    import lsbd_pkg::*;

    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic ce = 1'b1;
    logic start = 1'b0;
    logic [15:0] count_register = 16'h0000;
    logic bus8 = 1'b0;
    lsbd_instr_t instr;
    logic busy;
    logic done;
    lsbd_dec_t result;
    int n_fail = 0;
    int checks_done = 0;

    lsbd_prog_mem i_mem (.pc(8'h00), .instr(instr));
    lsbd_decoder i_dut (.clk(clk), .arst_n(arst_n), .ce(ce), .start(start), .instr(instr),
        .count_register(count_register), .bus8(bus8), .busy(busy), .done(done),
        .result(result));

    initial begin
        forever #12.5 clk = ~clk;
    end

    // ----------------------------------------------------------------
    // shared helpers
    // ----------------------------------------------------------------
    task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // counts busy samples until done shows; bounded so a hang ends the run
    task automatic wait_done(output int k);
        int i;
        k = 0;
        for (i = 0; i < 3000 && done !== 1'b1; i++) begin
            if (busy === 1'b1) k++;
            @(posedge clk);
            #1;
        end
        if (done !== 1'b1) begin
            chk("done wait", 24'h1, 24'h0);
            final_report();
        end
    endtask

    // bytes land while idle with start low, so nothing samples them half-written
    task automatic go(input logic [7:0] b0, input logic [7:0] b1, input logic [15:0] n,
            input logic b8);
        i_mem.mem[0] = b0;
        i_mem.mem[1] = b1;
        i_mem.mem[2] = 8'h00;
        @(posedge clk);
        start <= 1'b1;
        count_register <= n;
        bus8 <= b8;
        @(posedge clk);
        start <= 1'b0;
        #1;
    endtask

    task automatic run(input logic [7:0] b0, input logic [7:0] b1, input logic [15:0] n,
            input logic b8, input lsbd_op_t op, input logic [23:0] c, input logic w);
        int k;
        go(b0, b1, n, b8);
        wait_done(k);
        chk("busy length", c, 24'(k));
        chk("cycles", c, result.cycles);
        chk("op", 24'(op), 24'(result.op));
        chk("word", 24'(w), 24'(result.word));
        @(posedge clk);
        #1;
        chk("done pulse", 24'h0, 24'(done));
    endtask

    task automatic br(input logic [7:0] b0, input logic [7:0] b1, input logic b8,
            input logic unconditional_jump, input logic [23:0] c);
        run(b0, b1, 16'h0, b8, unconditional_jump ? op_unconditional_jump : op_call, c, 1'b1);
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_xor();
        run(8'h31, 8'hc0, 16'h0, 1'b0, op_xor, 24'h3, 1'b1);
        chk("reg_dest", 24'h0, 24'(result.reg_dest));
        run(8'h33, 8'h06, 16'h0, 1'b0, op_xor, 24'ha, 1'b1);
        chk("reg_dest", 24'h1, 24'(result.reg_dest));
        run(8'h33, 8'h06, 16'h0, 1'b1, op_xor, 24'he, 1'b1);
        run(8'h30, 8'h06, 16'h0, 1'b1, op_xor, 24'ha, 1'b0);
        run(8'h81, 8'hf0, 16'h0, 1'b0, op_xor, 24'h4, 1'b1);
        run(8'h81, 8'h36, 16'h0, 1'b1, op_xor, 24'h18, 1'b1);
        run(8'h80, 8'h36, 16'h0, 1'b1, op_xor, 24'h10, 1'b0);
        run(8'h34, 8'h00, 16'h0, 1'b0, op_xor, 24'h3, 1'b0);
        run(8'h35, 8'h00, 16'h0, 1'b1, op_xor, 24'h4, 1'b1);
        $display("test xor done");
    endtask

    task automatic t_not();
        run(8'hf7, 8'hd0, 16'h0, 1'b0, op_not, 24'h3, 1'b1);
        run(8'hf6, 8'h16, 16'h0, 1'b0, op_not, 24'ha, 1'b0);
        chk("mem_operand", 24'h1, 24'(result.mem_operand));
        run(8'hf7, 8'h16, 16'h0, 1'b1, op_not, 24'h12, 1'b1);
        $display("test not done");
    endtask

    // byte forms at list cost, word forms on the narrow bus pay per transfer
    task automatic t_strings();
        logic [7:0] opc [0:6] = '{8'ha4, 8'ha6, 8'hae, 8'hac, 8'haa, 8'h6c, 8'h6e};
        lsbd_op_t ops [0:6] = '{op_string_move, op_string_compare, op_string_scan,
            op_string_load, op_string_store, op_string_port_input, op_string_port_output};
        logic [23:0] cb [0:6] = '{24'he, 24'h16, 24'hf, 24'hc, 24'ha, 24'he, 24'he};
        logic [23:0] cw [0:6] = '{24'h16, 24'h1e, 24'h13, 24'h10, 24'he, 24'he, 24'he};
        for (int i = 0; i < 7; i++) begin
            run(opc[i], 8'h00, 16'h0, 1'b1, ops[i], cb[i], 1'b0);
            run(opc[i] | 8'h01, 8'h00, 16'h0, 1'b1, ops[i], cw[i], 1'b1);
        end
        $display("test strings done");
    endtask

    task automatic t_repeat();
        run(8'hf2, 8'ha5, 16'h3, 1'b0, op_string_move, 24'h20, 1'b1);
        run(8'hf3, 8'ha6, 16'h2, 1'b0, op_string_compare, 24'h31, 1'b0);
        chk("stop_on_equal", 24'h1, 24'(result.stop_on_equal));
        run(8'hf2, 8'haf, 16'h4, 1'b0, op_string_scan, 24'h41, 1'b1);
        run(8'hf2, 8'hac, 16'h1, 1'b0, op_string_load, 24'h11, 1'b0);
        run(8'hf2, 8'haa, 16'h5, 1'b0, op_string_store, 24'h33, 1'b0);
        run(8'hf2, 8'h6c, 16'h2, 1'b0, op_string_port_input, 24'h18, 1'b0);
        run(8'hf2, 8'h6f, 16'h0, 1'b1, op_string_port_output, 24'h8, 1'b1);
        run(8'hf2, 8'ha5, 16'h2, 1'b1, op_string_move, 24'h28, 1'b1);
        $display("test repeat done");
    endtask

    task automatic t_branch();
        br(8'heb, 8'h00, 1'b0, 1'b1, 24'he);
        br(8'he9, 8'h00, 1'b1, 1'b1, 24'he);
        br(8'hea, 8'h00, 1'b1, 1'b1, 24'he);
        br(8'hff, 8'he0, 1'b0, 1'b1, 24'hb);
        br(8'hff, 8'h26, 1'b0, 1'b1, 24'h11);
        br(8'hff, 8'h26, 1'b1, 1'b1, 24'h15);
        br(8'hff, 8'h2e, 1'b0, 1'b1, 24'h1a);
        br(8'hff, 8'h2e, 1'b1, 1'b1, 24'h22);
        chk("far", 24'h1, 24'(result.far));
        chk("indirect", 24'h1, 24'(result.indirect));
        br(8'he8, 8'h00, 1'b0, 1'b0, 24'hf);
        chk("near far", 24'h0, 24'(result.far));
        chk("near indirect", 24'h0, 24'(result.indirect));
        br(8'he8, 8'h00, 1'b1, 1'b0, 24'h13);
        br(8'h9a, 8'h00, 1'b1, 1'b0, 24'h1f);
        br(8'hff, 8'hd0, 1'b1, 1'b0, 24'h11);
        br(8'hff, 8'h16, 1'b0, 1'b0, 24'h13);
        br(8'hff, 8'h1e, 1'b0, 1'b0, 24'h26);
        br(8'hff, 8'h1e, 1'b1, 1'b0, 24'h36);
        $display("test branch done");
    endtask

    // far indirect forms through a register, and opcode 90 which no branch decodes, have no meaning
    task automatic t_illegal();
        logic [15:0] code [0:2] = '{16'hffd8, 16'hffe8, 16'h9000};
        int k;
        for (int i = 0; i < 3; i++) begin
            go(code[i][15:8], code[i][7:0], 16'h0, 1'b0);
            wait_done(k);
            chk("illegal busy", 24'h0, 24'(k));
            chk("illegal flag", 24'h1, 24'(result.illegal));
        end
        $display("test illegal done");
    endtask

    // start held high: ignored while busy, taken again in the done cycle
    task automatic t_hold();
        int k;
        go(8'ha4, 8'h00, 16'h0, 1'b0);
        start <= 1'b1;
        i_mem.mem[0] = 8'hae;
        repeat (3) @(posedge clk);
        ce <= 1'b0;
        repeat (5) @(posedge clk);
        ce <= 1'b1;
        #1;
        // three enabled edges already passed, so eleven busy samples remain
        wait_done(k);
        chk("frozen busy", 24'hb, 24'(k));
        chk("first op", 24'(op_string_move), 24'(result.op));
        @(posedge clk);
        start <= 1'b0;
        #1;
        wait_done(k);
        chk("second busy", 24'hf, 24'(k));
        chk("second op", 24'(op_string_scan), 24'(result.op));
        $display("test hold done");
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (3) @(posedge clk);
        #1;
        chk("reset busy", 24'h0, 24'(busy));
        chk("reset done", 24'h0, 24'(done));
        chk("reset op", 24'h0, 24'(result.op));
        @(posedge clk);
        arst_n <= 1'b1;
        t_xor();
        t_not();
        t_strings();
        t_repeat();
        t_branch();
        t_illegal();
        t_hold();
        final_report();
    end
endmodule
